// >>> hw/fpes_pkg.sv
// Purpose: shared constants for the flash program/erase/suspend sequencer
// Assumes: 10 MHz ref_clk, SPI mode 0 from the host
// Notes: times are in nanoseconds; the resume cycle count is derived from them
package fpes_pkg;
	// Clock period of ref_clk in ns
	localparam int unsigned CLK_PERIOD_NS = 100;
	// Opcodes
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_QPP = 8'h32;
	localparam logic [7:0] OP_SECPP = 8'h42;
	localparam logic [7:0] OP_SE = 8'h20;
	localparam logic [7:0] OP_BE32 = 8'h52;
	localparam logic [7:0] OP_BE64 = 8'hd8;
	localparam logic [7:0] OP_CE1 = 8'hc7;
	localparam logic [7:0] OP_CE2 = 8'h60;
	localparam logic [7:0] OP_SECER = 8'h44;
	localparam logic [7:0] OP_SUSP = 8'h75;
	localparam logic [7:0] OP_RESM = 8'h7a;
	localparam logic [7:0] OP_RDSR = 8'h05;
	// Page geometry
	localparam int unsigned PAGE_BYTES = 256;
	localparam int unsigned ADDR_BITS = 24;
	// Bit counts of the command phases
	localparam logic [5:0] OPC_BITS = 6'h08;
	localparam logic [5:0] ADDR_END_BITS = 6'h20;
	// Resume sets busy within this time
	localparam int unsigned RESUME_BUSY_NS = 200;
	localparam int unsigned RESUME_BUSY_CYC = (RESUME_BUSY_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(RESUME_BUSY_NS / CLK_PERIOD_NS);
	// Default self-timed cycle counts (shortened by top parameters)
	localparam int unsigned PROG_CYC_DEF = 4000;
	localparam int unsigned SECTOR_ERASE_CYC_DEF = 500000;
	localparam int unsigned HALF_BLOCK_ERASE_CYC_DEF = 1600000;
	localparam int unsigned FULL_BLOCK_ERASE_CYC_DEF = 1500000;
	localparam int unsigned ARRAY_ERASE_CYC_DEF = 400000000;
	localparam int unsigned SUSPEND_CYC_DEF = 200;
	// Kinds of internal operation
	typedef enum logic [2:0] {
		FPES_OP_PROG,
		FPES_OP_SECTOR,
		FPES_OP_HALF,
		FPES_OP_FULL,
		FPES_OP_ARRAY
	} fpes_op_e;
endpackage

// >>> hw/fpes_seq.sv
// Purpose: program, erase and suspend sequencer of a serial NOR flash
// Assumes: host runs SPI mode 0; pins are asynchronous to ref_clk
// Notes: array itself is outside; this block issues write strobes
// Operation
// - Quad program needs quad enable bit set
// - Quad program: 32h, address, quad data
// - Up to 256 bytes into page buffer
// - 20h erases addressed 4K sector
// - 52h erases addressed 32K block
// - D8h erases addressed 64K block
// - C7h or 60h erases whole array
// - Program/erase refused without write enable latch
// - Chip select late rise discards command
// - Busy set during self-timed cycle
// - Write enable latch cleared on completion
// - Protected regions are never programmed or erased; whole-array erase checks any block-protect bit and the lock at address 0
// - Suspend only while busy, not suspended
// - Suspend ignored during whole-array erase
// - Erase suspended refuses status write, erases
// - Program suspended refuses status write, programs
// - Suspend flag immediate, busy clears within latency
// - Other regions usable while suspended
// - Power loss reset clears suspend flag
// - Page addressing wraps at 256 bytes
// - Resume clears flag, busy within 200ns
`timescale 1ns/1ps
module fpes_seq
	import fpes_pkg::*;
#(
	parameter int unsigned PROG_CYC = PROG_CYC_DEF,
	parameter int unsigned SECTOR_ERASE_CYC = SECTOR_ERASE_CYC_DEF,
	parameter int unsigned HALF_BLOCK_ERASE_CYC = HALF_BLOCK_ERASE_CYC_DEF,
	parameter int unsigned FULL_BLOCK_ERASE_CYC = FULL_BLOCK_ERASE_CYC_DEF,
	parameter int unsigned ARRAY_ERASE_CYC = ARRAY_ERASE_CYC_DEF,
	parameter int unsigned SUSPEND_CYC = SUSPEND_CYC_DEF
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] io_in,
	input wire logic quad_enable_bit,
	input wire logic protect_complement,
	input wire logic sector_granularity_select,
	input wire logic top_bottom_select,
	input wire logic block_protect_hi,
	input wire logic block_protect_mid,
	input wire logic block_protect_lo,
	input wire logic region_locked,
	output logic busy,
	output logic write_enable_latch,
	output logic suspend_flag,
	output logic [23:0] lock_query_addr,
	output logic wr_stb,
	output logic [23:0] wr_addr,
	output logic [7:0] wr_data,
	output logic erase_stb,
	output logic [2:0] erase_kind,
	output logic [23:0] erase_addr,
	output logic status_write_ok
);
	import fpes_pkg::*;
	initial begin
		if (PROG_CYC < 1 || SUSPEND_CYC < 1 || SECTOR_ERASE_CYC < 1 || ARRAY_ERASE_CYC < 1
			|| HALF_BLOCK_ERASE_CYC < 1 || FULL_BLOCK_ERASE_CYC < 1)
			$error("fpes_seq: cycle counts must be at least one");
	end
	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic cs_n_s, sclk_s, sclk_d;
	logic [3:0] io_s;
	fpes_sync #(.RESET_VAL(1'b1)) u_cs (.clk(ref_clk), .rst(rst), .d(cs_n), .q(cs_n_s));
	fpes_sync #(.RESET_VAL(1'b0)) u_ck (.clk(ref_clk), .rst(rst), .d(sclk), .q(sclk_s));
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_io
			fpes_sync #(.RESET_VAL(1'b0)) u_io (.clk(ref_clk), .rst(rst), .d(io_in[gi]), .q(io_s[gi]));
		end
	endgenerate
	logic sclk_rise; // Rising edge pulse of the serial clock
	logic cs_d; // Delayed chip select
	logic cs_rise; // Frame end pulse
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sclk_d <= 1'b0;
			cs_d <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
			cs_d <= cs_n_s;
		end
	end
	assign sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
	assign cs_rise = cs_n_s & ~cs_d;
	////////////////////////////////////////////////////////////////////////////////
	// Frame shifter
	logic [7:0] opcode, data_byte;
	logic [23:0] addr;
	logic data_valid, byte_done;
	logic [5:0] bit_cnt;
	logic [8:0] data_cnt;
	fpes_shift u_shift (
		.ref_clk(ref_clk), .rst(rst), .cs_n_s(cs_n_s), .sclk_rise(sclk_rise), .io_s(io_s),
		.opcode(opcode), .addr(addr), .data_byte(data_byte), .data_valid(data_valid),
		.byte_done(byte_done), .bit_cnt(bit_cnt), .data_cnt(data_cnt)
	);
	////////////////////////////////////////////////////////////////////////////////
	// Page buffer filled during a program frame
	logic [7:0] page_mem [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] page_vld_reg;
	logic [7:0] wptr_reg; // Wrapping byte pointer in the page
	logic buf_open; // Frame is a program that may load the buffer
	// Pointer follows the low address byte until the first data byte lands
	always_ff @(posedge ref_clk) begin
		if (rst || data_cnt == 9'h000) begin
			wptr_reg <= addr[7:0];
		end else if (data_valid && buf_open) begin
			page_mem[wptr_reg] <= data_byte;
			wptr_reg <= wptr_reg + 8'h01;
		end
	end
	// Byte valid map; status reads and frames during a parked program leave it alone
	always_ff @(posedge ref_clk) begin
		if (rst)
			page_vld_reg <= '0;
		else if (!cs_n_s && data_cnt == 9'h000 && bit_cnt >= OPC_BITS && buf_open)
			page_vld_reg <= '0;
		else if (data_valid && buf_open)
			page_vld_reg[wptr_reg] <= 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Protection: block-protect bits or a lock on the addressed region
	logic bp_any; // Any protection configured
	assign bp_any = block_protect_hi | block_protect_mid | block_protect_lo | protect_complement;
	assign lock_query_addr = addr;
	logic region_prot; // Addressed region is protected
	always_comb begin
		region_prot = region_locked;
		if (bp_any) begin
			// Coarse map: protect top or bottom span chosen by the select bits
			region_prot = region_locked | (addr[23] == ~top_bottom_select) ^ protect_complement
				| (sector_granularity_select & addr[23:22] == {~top_bottom_select, ~top_bottom_select});
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Command decode at frame end
	logic frame_ok; // Ended on a byte boundary
	logic is_prog, is_erase, is_array;
	assign frame_ok = byte_done
		&& (bit_cnt == OPC_BITS || bit_cnt == ADDR_END_BITS || data_cnt != 9'h000);
	assign is_prog = (opcode == OP_PP) || (opcode == OP_QPP);
	assign is_array = (opcode == OP_CE1) || (opcode == OP_CE2);
	assign is_erase = (opcode == OP_SE) || (opcode == OP_BE32) || (opcode == OP_BE64) || is_array;
	// Suspended operation kind
	fpes_op_e op_reg, susp_op_reg;
	logic susp_is_erase;
	assign susp_is_erase = suspend_flag && susp_op_reg != FPES_OP_PROG;
	// A parked program keeps its page; only an idle, unblocked program reloads it
	assign buf_open = is_prog && !busy && !(suspend_flag && !susp_is_erase);
	logic refuse; // Command refused in current state
	always_comb begin
		refuse = busy || !write_enable_latch;
		if (opcode == OP_QPP && !quad_enable_bit) refuse = 1'b1;
		if (is_prog && (bit_cnt != ADDR_END_BITS || data_cnt == 9'h000)) refuse = 1'b1;
		if (is_erase && !is_array && (bit_cnt != ADDR_END_BITS || data_cnt != 9'h000)) refuse = 1'b1;
		if (is_array && bit_cnt != OPC_BITS) refuse = 1'b1;
		if (is_erase && susp_is_erase) refuse = 1'b1;
		if (is_prog && suspend_flag && !susp_is_erase) refuse = 1'b1;
		if (is_array ? (bp_any | region_locked) : region_prot) refuse = 1'b1;
	end
	logic start_op; // Accepted program or erase
	assign start_op = cs_rise && frame_ok && (is_prog || is_erase) && !refuse;
	assign status_write_ok = !suspend_flag;
	logic susp_cmd, resm_cmd, wren_cmd;
	assign susp_cmd = cs_rise && frame_ok && bit_cnt == OPC_BITS && opcode == OP_SUSP;
	assign resm_cmd = cs_rise && frame_ok && bit_cnt == OPC_BITS && opcode == OP_RESM;
	assign wren_cmd = cs_rise && frame_ok && bit_cnt == OPC_BITS && opcode == OP_WREN && !busy;
	////////////////////////////////////////////////////////////////////////////////
	// Self-timed cycle sequencer
	typedef enum logic [1:0] {FPES_IDLE, FPES_RUN, FPES_SUSPING, FPES_RESUMING} fpes_state_e;
	fpes_state_e st_reg;
	logic [31:0] cnt_reg; // Remaining cycles of the operation
	logic [31:0] lat_reg; // Suspend or resume latency counter
	logic [23:0] op_addr_reg;
	logic [31:0] susp_cnt_reg; // Remaining cycles parked by a suspend
	logic [23:0] susp_addr_reg; // Target address parked by a suspend
	logic [8:0] prog_idx_reg; // Page write-out index
	logic susp_ok;
	assign susp_ok = busy && !suspend_flag && st_reg == FPES_RUN && op_reg != FPES_OP_ARRAY;
	function automatic logic [31:0] op_len(input fpes_op_e k);
		unique case (k)
			FPES_OP_PROG: op_len = 32'(PROG_CYC);
			FPES_OP_SECTOR: op_len = 32'(SECTOR_ERASE_CYC);
			FPES_OP_HALF: op_len = 32'(HALF_BLOCK_ERASE_CYC);
			FPES_OP_FULL: op_len = 32'(FULL_BLOCK_ERASE_CYC);
			FPES_OP_ARRAY: op_len = 32'(ARRAY_ERASE_CYC);
		endcase
	endfunction
	fpes_op_e new_op;
	always_comb begin
		unique case (opcode)
			OP_SE: new_op = FPES_OP_SECTOR;
			OP_BE32: new_op = FPES_OP_HALF;
			OP_BE64: new_op = FPES_OP_FULL;
			OP_PP, OP_QPP: new_op = FPES_OP_PROG;
			default: new_op = FPES_OP_ARRAY;
		endcase
	end
	// Sequencer state, busy and suspend flag
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_reg <= FPES_IDLE;
			busy <= 1'b0;
			suspend_flag <= 1'b0;
			cnt_reg <= 32'h00000000;
			lat_reg <= 32'h00000000;
			op_reg <= FPES_OP_PROG;
			susp_op_reg <= FPES_OP_PROG;
			op_addr_reg <= 24'h000000;
			susp_cnt_reg <= 32'h00000000;
			susp_addr_reg <= 24'h000000;
		end else begin
			unique case (st_reg)
				FPES_IDLE: begin
					if (start_op) begin
						st_reg <= FPES_RUN;
						busy <= 1'b1;
						op_reg <= new_op;
						op_addr_reg <= addr;
						cnt_reg <= op_len(new_op);
					end else if (resm_cmd && suspend_flag) begin
						suspend_flag <= 1'b0;
						op_reg <= susp_op_reg;
						cnt_reg <= susp_cnt_reg; // Parked work picks up where it stopped
						op_addr_reg <= susp_addr_reg;
						st_reg <= FPES_RESUMING;
						lat_reg <= 32'(RESUME_BUSY_CYC - 1);
					end
				end
				FPES_RUN: begin
					if (susp_cmd && susp_ok) begin
						suspend_flag <= 1'b1;
						susp_op_reg <= op_reg;
						susp_cnt_reg <= cnt_reg; // An operation in the gap must not lose this work
						susp_addr_reg <= op_addr_reg;
						st_reg <= FPES_SUSPING;
						lat_reg <= 32'(SUSPEND_CYC - 1);
					end else if (cnt_reg <= 32'h00000001) begin
						st_reg <= FPES_IDLE;
						busy <= 1'b0;
					end else begin
						cnt_reg <= cnt_reg - 32'h00000001;
					end
				end
				FPES_SUSPING: begin
					if (lat_reg == 32'h00000000) begin
						busy <= 1'b0;
						st_reg <= FPES_IDLE;
					end else
						lat_reg <= lat_reg - 32'h00000001;
				end
				FPES_RESUMING: begin
					if (lat_reg == 32'h00000000) begin
						busy <= 1'b1;
						st_reg <= FPES_RUN;
					end else
						lat_reg <= lat_reg - 32'h00000001;
				end
			endcase
		end
	end
	// Write enable latch: set by write enable, cleared at completion
	logic op_done;
	assign op_done = st_reg == FPES_RUN && !(susp_cmd && susp_ok) && cnt_reg <= 32'h00000001;
	always_ff @(posedge ref_clk) begin
		if (rst)
			write_enable_latch <= 1'b0;
		else if (wren_cmd)
			write_enable_latch <= 1'b1;
		else if (op_done)
			write_enable_latch <= 1'b0;
	end
	// Array strobes at completion; program writes one byte per cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			erase_stb <= 1'b0;
			erase_kind <= 3'h0;
			erase_addr <= 24'h000000;
			wr_stb <= 1'b0;
			wr_addr <= 24'h000000;
			wr_data <= 8'h00;
			prog_idx_reg <= 9'h100;
		end else begin
			erase_stb <= op_done && op_reg != FPES_OP_PROG;
			erase_kind <= op_reg;
			erase_addr <= op_addr_reg;
			wr_stb <= 1'b0;
			if (op_done && op_reg == FPES_OP_PROG)
				prog_idx_reg <= 9'h000;
			else if (!prog_idx_reg[8]) begin
				prog_idx_reg <= prog_idx_reg + 9'h001;
				wr_stb <= page_vld_reg[prog_idx_reg[7:0]];
				wr_addr <= {op_addr_reg[23:8], prog_idx_reg[7:0]};
				wr_data <= page_mem[prog_idx_reg[7:0]];
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_latch_clear: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(busy) && !suspend_flag |-> !write_enable_latch) else $error("latch not cleared");
	chk_susp_busy: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(suspend_flag) |-> busy ##[1:300] !busy) else $error("busy not cleared after suspend");
	chk_resume_busy: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(suspend_flag) |-> ##[1:2] busy) else $error("busy late after resume");
	chk_start_latch: assert property (@(posedge ref_clk) disable iff (rst)
		start_op |-> write_enable_latch) else $error("op without latch");
	chk_quad_needs_enable: assert property (@(posedge ref_clk) disable iff (rst)
		start_op && opcode == OP_QPP |-> quad_enable_bit) else $error("quad without enable");
	chk_array_nosusp: assert property (@(posedge ref_clk) disable iff (rst)
		st_reg == FPES_RUN && op_reg == FPES_OP_ARRAY |=> !$rose(suspend_flag)) else $error("array suspended");
	chk_busy_ignore: assert property (@(posedge ref_clk) disable iff (rst)
		busy |-> !start_op) else $error("command taken while busy");
	chk_prot: assert property (@(posedge ref_clk) disable iff (rst)
		start_op |-> !region_prot) else $error("protected op");
endmodule // fpes_seq

// >>> hw/fpes_shift.sv
// Purpose: SPI frame shifter, single or quad input
// Assumes: synchronised cs_n, clock edge pulse and io levels
// Notes: counts bits; reports opcode, address and each data byte
`timescale 1ns/1ps
module fpes_shift
	import fpes_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cs_n_s,
	input wire logic sclk_rise,
	input wire logic [3:0] io_s,
	output logic [7:0] opcode,
	output logic [23:0] addr,
	output logic [7:0] data_byte,
	output logic data_valid,
	output logic byte_done,
	output logic [5:0] bit_cnt,
	output logic [8:0] data_cnt
);
	import fpes_pkg::*;
	logic [7:0] sh_reg;
	logic [2:0] sub_reg;
	logic quad;
	// Quad lanes carry the data after the address of a quad program
	assign quad = (bit_cnt == ADDR_END_BITS) && (opcode == OP_QPP);
	// Shifting and byte counting
	always_ff @(posedge ref_clk) begin
		if (rst || cs_n_s) begin
			sh_reg <= 8'h00;
			sub_reg <= 3'h0;
			bit_cnt <= 6'h00;
			opcode <= 8'h00;
			addr <= 24'h000000;
			data_byte <= 8'h00;
			data_valid <= 1'b0;
			byte_done <= 1'b0;
			data_cnt <= 9'h000;
		end else begin
			data_valid <= 1'b0;
			if (sclk_rise) begin
				byte_done <= 1'b0;
				if (bit_cnt < ADDR_END_BITS) begin
					// Opcode and address come in on one line
					bit_cnt <= bit_cnt + 6'h01;
					if (bit_cnt < OPC_BITS)
						opcode <= {opcode[6:0], io_s[0]};
					else
						addr <= {addr[22:0], io_s[0]};
					byte_done <= (bit_cnt[2:0] == 3'h7);
				end else if (quad) begin
					// Four bits per edge
					sh_reg <= {sh_reg[3:0], io_s};
					sub_reg <= sub_reg + 3'h4;
					if (sub_reg == 3'h4) begin
						data_byte <= {sh_reg[3:0], io_s};
						data_valid <= 1'b1;
						byte_done <= 1'b1;
						data_cnt <= data_cnt + 9'h001;
					end
				end else begin
					sh_reg <= {sh_reg[6:0], io_s[0]};
					sub_reg <= sub_reg + 3'h1;
					if (sub_reg == 3'h7) begin
						data_byte <= {sh_reg[6:0], io_s[0]};
						data_valid <= 1'b1;
						byte_done <= 1'b1;
						data_cnt <= data_cnt + 9'h001;
					end
				end
			end
		end
	end
endmodule // fpes_shift

// >>> hw/fpes_sync.sv
// Purpose: two-stage synchroniser for one bit
// Assumes: input is asynchronous to clk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module fpes_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic d,
	output logic q
);
	logic meta_reg;
	// Two flops in series
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= RESET_VAL;
			q <= RESET_VAL;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule // fpes_sync

// >>> tb/fpes_host.sv
// Purpose: host SPI controller model facing the sequencer
// Assumes: mode 0, MSB first, sclk period 800 ns
// Notes: sclk stands low between frames; idle IO lines keep toggling
`timescale 1ns/1ps
module fpes_host
	import fpes_pkg::*;
(
	output logic cs_n,
	output logic sclk,
	output logic [3:0] io_in
);
	logic [7:0] dat [0:7]; // Data bytes of the next frame
	// Idle pins at time zero
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		io_in = 4'h0;
	end
	// One sclk cycle; lines change while sclk is low
	task automatic bitq(input logic [3:0] v);
		io_in = v;
		#400 sclk = 1'b1;
		#400 sclk = 1'b0;
	endtask
	// Single-line bit on IO0; unused lines keep changing
	task automatic bit1(input logic b);
		bitq({~io_in[3:1], b});
	endtask
	// Whole frame: opcode, address where the opcode takes one, data
	task automatic send(input logic [7:0] c, input logic [23:0] a, input int nb, input bit q, input bit late);
		cs_n = 1'b0;
		#400;
		for (int i = 7; i >= 0; i--) bit1(c[i]);
		if (!(c inside {OP_WREN, OP_CE1, OP_CE2, OP_SUSP, OP_RESM, OP_RDSR}))
			for (int i = 23; i >= 0; i--) bit1(a[i]);
		for (int j = 0; j < nb; j++)
			if (q) begin
				bitq(dat[j][7:4]);
				bitq(dat[j][3:0]);
			end else
				for (int i = 7; i >= 0; i--) bit1(dat[j][i]);
		// Stray bits past the last byte
		if (late)
			for (int i = 0; i < 4; i++) bit1(i[0]);
		#400 cs_n = 1'b1;
		io_in = ~io_in;
		#1200;
	endtask
endmodule // fpes_host

// >>> tb/test_flash_program_erase_suspend.sv
// Purpose: self-checking bench of the program/erase/suspend sequencer
// Assumes: shortened self-timed counts set below
// Notes: the host model drives cs_n, sclk and io_in
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR %s expected %0h seen %0h", n, e, g); end end
module test_flash_program_erase_suspend;
	import fpes_pkg::*;
	localparam int unsigned LONG = 300;
	localparam int unsigned ALONG = 600;
	localparam int unsigned SUSP_LAT = 20;
	logic ref_clk, rst, cs_n, sclk, quad_enable_bit, region_locked;
	logic protect_complement, sector_granularity_select, top_bottom_select;
	logic block_protect_hi, block_protect_mid, block_protect_lo;
	logic [3:0] io_in;
	logic busy, write_enable_latch, suspend_flag, wr_stb, erase_stb, status_write_ok;
	logic [23:0] lock_query_addr, wr_addr, erase_addr, er_a, a, lq_a;
	logic [7:0] wr_data;
	logic [2:0] erase_kind, er_k;
	logic [7:0] seen [logic [23:0]]; // Bytes handed to the array
	int mismatches, tests_run, wr_n, er_n;
	logic [7:0] ops [5] = '{OP_SE, OP_BE32, OP_BE64, OP_CE1, OP_CE2};
	int sh [5] = '{12, 15, 16, 0, 0}; // Alignment of each erase unit
	fpes_seq #(.PROG_CYC(LONG), .SECTOR_ERASE_CYC(LONG), .HALF_BLOCK_ERASE_CYC(40),
		.FULL_BLOCK_ERASE_CYC(45), .ARRAY_ERASE_CYC(ALONG), .SUSPEND_CYC(SUSP_LAT)) uut (.ref_clk, .rst,
		.cs_n, .sclk, .io_in, .quad_enable_bit, .protect_complement, .sector_granularity_select,
		.top_bottom_select, .block_protect_hi, .block_protect_mid, .block_protect_lo, .region_locked,
		.busy, .write_enable_latch, .suspend_flag, .lock_query_addr, .wr_stb, .wr_addr, .wr_data,
		.erase_stb, .erase_kind, .erase_addr, .status_write_ok);
	fpes_host host (.cs_n, .sclk, .io_in);
	////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// Records strobes away from the launching edge
	always @(negedge ref_clk) begin
		// Last address offered for a lock lookup
		if (lock_query_addr != 24'h0)
			lq_a = lock_query_addr;
		if (wr_stb) begin
			wr_n++;
			seen[wr_addr] = wr_data;
		end
		if (erase_stb) begin
			er_n++;
			er_k = erase_kind;
			er_a = erase_addr;
		end
	end
	////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic close_out();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Waits, bounded, for busy to reach a level
	task automatic wait_busy(input logic v, input int lim);
		int n;
		n = 0;
		while (busy !== v && n < lim) begin
			@(negedge ref_clk);
			n++;
		end
		`CHK("busy", v, busy)
		repeat (4) @(negedge ref_clk);
	endtask
	// Write enable, then one frame with fresh strobe records
	task automatic op(input logic [7:0] c, input logic [23:0] ad, input int nb, input bit q);
		host.send(OP_WREN, 24'h0, 0, 1'b0, 1'b0);
		wr_n = 0;
		er_n = 0;
		seen.delete();
		host.send(c, ad, nb, q, 1'b0);
	endtask
	// Expected kind reported for an erase opcode
	function automatic logic [2:0] kind_of(input logic [7:0] c);
		case (c)
			OP_SE: return 3'(FPES_OP_SECTOR);
			OP_BE32: return 3'(FPES_OP_HALF);
			OP_BE64: return 3'(FPES_OP_FULL);
			default: return 3'(FPES_OP_ARRAY);
		endcase
	endfunction
	////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		#6000000;
		mismatches++;
		close_out();
	end
	// Main sequence
	initial begin
		{rst, quad_enable_bit, region_locked} = 3'b100;
		{protect_complement, sector_granularity_select, top_bottom_select} = 3'h0;
		{block_protect_hi, block_protect_mid, block_protect_lo} = 3'h0;
		{mismatches, tests_run, wr_n, er_n} = '0;
		void'($urandom(32'h427ea5fd));
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk) rst = 1'b0;
		repeat (3) @(negedge ref_clk);
		`CHK("write_enable_latch", 1'b0, write_enable_latch)
		host.send(OP_SE, 24'h001000, 0, 1'b0, 1'b0);
		`CHK("busy", 1'b0, busy)
		$display("test no_latch done");
		foreach (ops[i]) begin
			a = 24'($urandom()) & ~((24'h1 << sh[i]) - 24'h1);
			op(ops[i], a, 0, 1'b0);
			`CHK("busy", 1'b1, busy)
			wait_busy(1'b0, ALONG + 50);
			`CHK("write_enable_latch", 1'b0, write_enable_latch)
			`CHK("kind", kind_of(ops[i]), er_k)
			if (sh[i] != 0) `CHK("erase_addr", a, er_a)
		end
		$display("test erase_kinds done");
		op(OP_QPP, 24'h0, 1, 1'b1);
		`CHK("busy", 1'b0, busy)
		@(negedge ref_clk) quad_enable_bit = 1'b1;
		for (int j = 0; j < 4; j++) host.dat[j] = 8'($urandom());
		a = {16'($urandom()), 8'hfe};
		op(OP_QPP, a, 4, 1'b1);
		`CHK("busy", 1'b1, busy)
		wait_busy(1'b0, LONG + 50);
		repeat (260) @(negedge ref_clk);
		`CHK("writes", 4, wr_n)
		`CHK("first", host.dat[0], seen[a])
		`CHK("wrap", host.dat[3], seen[{a[23:8], 8'h01}])
		$display("test quad done");
		host.send(OP_WREN, 24'h0, 0, 1'b0, 1'b0);
		host.send(OP_SE, 24'h002000, 0, 1'b0, 1'b1);
		`CHK("busy", 1'b0, busy)
		@(negedge ref_clk) region_locked = 1'b1;
		op(OP_SE, 24'h003000, 0, 1'b0);
		`CHK("busy", 1'b0, busy)
		`CHK("lock_query_addr", 24'h003000, lq_a)
		@(negedge ref_clk) region_locked = 1'b0;
		{block_protect_hi, block_protect_mid, block_protect_lo} = 3'($urandom_range(7, 1));
		{protect_complement, sector_granularity_select, top_bottom_select} = 3'($urandom());
		op(OP_CE1, 24'h0, 0, 1'b0);
		`CHK("busy", 1'b0, busy)
		@(negedge ref_clk) {block_protect_hi, block_protect_mid, block_protect_lo} = 3'h0;
		{protect_complement, sector_granularity_select, top_bottom_select} = 3'h0;
		$display("test refusals done");
		host.send(OP_SUSP, 24'h0, 0, 1'b0, 1'b0);
		`CHK("suspend", 1'b0, suspend_flag)
		host.send(OP_RESM, 24'h0, 0, 1'b0, 1'b0);
		`CHK("busy", 1'b0, busy)
		op(OP_CE2, 24'h0, 0, 1'b0);
		host.send(OP_RDSR, 24'h0, 0, 1'b0, 1'b0);
		`CHK("busy", 1'b1, busy)
		host.send(OP_SUSP, 24'h0, 0, 1'b0, 1'b0);
		`CHK("suspend", 1'b0, suspend_flag)
		host.send(OP_SE, 24'h005000, 0, 1'b0, 1'b0);
		wait_busy(1'b0, ALONG + 50);
		`CHK("erases", 1, er_n)
		$display("test array_busy done");
		a = {12'($urandom()), 12'h0};
		op(OP_SE, a, 0, 1'b0);
		host.send(OP_SUSP, 24'h0, 0, 1'b0, 1'b0);
		`CHK("suspend", 1'b1, suspend_flag)
		wait_busy(1'b0, SUSP_LAT + 5);
		`CHK("status_write_ok", 1'b0, status_write_ok)
		op(OP_BE64, a, 0, 1'b0);
		`CHK("busy", 1'b0, busy)
		host.dat[0] = 8'($urandom());
		op(OP_PP, a ^ 24'h800000, 1, 1'b0);
		`CHK("busy", 1'b1, busy)
		wait_busy(1'b0, LONG + 50);
		repeat (260) @(negedge ref_clk);
		`CHK("writes", 1, wr_n)
		host.send(OP_RESM, 24'h0, 0, 1'b0, 1'b0);
		`CHK("suspend", 1'b0, suspend_flag)
		`CHK("busy", 1'b1, busy)
		repeat (SUSP_LAT) @(negedge ref_clk);
		host.send(OP_SUSP, 24'h0, 0, 1'b0, 1'b0);
		`CHK("suspend", 1'b1, suspend_flag)
		wait_busy(1'b0, SUSP_LAT + 5);
		host.send(OP_RESM, 24'h0, 0, 1'b0, 1'b0);
		`CHK("busy", 1'b1, busy)
		wait_busy(1'b0, LONG + 50);
		`CHK("kind", 3'(FPES_OP_SECTOR), er_k)
		`CHK("erase_addr", a, er_a)
		$display("test erase_suspend done");
		op(OP_PP, a, 1, 1'b0);
		host.send(OP_SUSP, 24'h0, 0, 1'b0, 1'b0);
		`CHK("suspend", 1'b1, suspend_flag)
		wait_busy(1'b0, SUSP_LAT + 5);
		`CHK("status_write_ok", 1'b0, status_write_ok)
		op(OP_QPP, a, 1, 1'b1);
		`CHK("busy", 1'b0, busy)
		@(negedge ref_clk) rst = 1'b1;
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		repeat (3) @(negedge ref_clk);
		`CHK("suspend", 1'b0, suspend_flag)
		`CHK("status_write_ok", 1'b1, status_write_ok)
		$display("test program_suspend done");
		close_out();
	end
endmodule // test_flash_program_erase_suspend
